// [src/tdd_top.sv]
// Purpose: hardware trigger debounce plus acquisition/frame trigger delay
// Assumes: inputs synchronous to clk; settings static while triggers flow
// Notes:   tick from clk; software/internal triggers bypass the delay
// Behaviour
// - level change accepted only after holding steady for debounce time
// - pulses shorter than debounce time are discarded
// - valid rising edge forwarded delayed by the debounce time
// - debounce time set in microseconds, zero to about one second
// - debounce setting applies to selected line; first line has debouncer
// - programmable microsecond delay between hardware trigger and action
// - trigger delay ranges zero to ten million microseconds
// - zero delay means trigger acts without added delay
// - delay may apply to hardware acquisition-start trigger in both schemes
// - default scheme also allows delay on hardware frame-start trigger
// - no delay on internal or software acquisition-start triggers
// - no delay on internal or software frame-start triggers
`timescale 1ns/1ps
module tdd_top
  import tdd_pkg::*;
(
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         nrst,
  // input line
  input  wire logic                         first_input_line,
  // debouncer settings
  input  wire logic [1:0]                   line_sel,
  input  wire logic [tdd_pkg::DEB_W-1:0]    debounce_us,
  input  wire logic [tdd_pkg::DEB_W-1:0]    debounce_wr_val,
  // scheme and triggers
  input  wire tdd_pkg::tdd_scheme_e         scheme,
  input  wire tdd_pkg::tdd_trig_cfg_s       acq_cfg,
  input  wire tdd_pkg::tdd_trig_cfg_s       frm_cfg,
  input  wire logic                         internal_acq,
  input  wire logic                         internal_frm,
  // outputs
  output logic                              line_debounced_q,
  output tdd_pkg::tdd_trig_out_s            acq_out_q,
  output tdd_pkg::tdd_trig_out_s            frm_out_q
);
  logic [1:0]       rst_sync_q;
  logic             rst_n;
  logic [7:0]       tick_cnt_q;
  logic             tick_q;
  logic [DEB_W-1:0] deb_time_q;
  logic [DEB_W-1:0] deb_cnt_q;
  logic             hw_edge_q;
  logic             acq_fire, acq_busy, frm_fire, frm_busy;
  logic             acq_apply, frm_apply;
  logic             acq_sw, frm_sw;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rst_sync_q <= 2'h0;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // microsecond timebase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 8'h00;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 8'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= 8'h00;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 8'h01;
      tick_q     <= 1'b0;
    end
  end

  // debounce time latched only when first line is selected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) deb_time_q <= '0;
    else if (debounce_wr_val == debounce_us && line_sel == LINE_SEL_FIRST) begin
      deb_time_q <= (debounce_us > DEB_W'(DEB_MAX_US)) ? DEB_W'(DEB_MAX_US) : debounce_us;
    end
  end

  // debouncer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_debounced_q <= LINE_RST;
      deb_cnt_q        <= '0;
      hw_edge_q        <= 1'b0;
    end else begin
      hw_edge_q <= 1'b0;
      if (first_input_line == line_debounced_q) begin
        deb_cnt_q <= '0;
      end else if (deb_time_q == '0 || deb_cnt_q > deb_time_q) begin
        // one extra tick covers the partial first microsecond
        line_debounced_q <= first_input_line;
        deb_cnt_q        <= '0;
        hw_edge_q        <= first_input_line;
      end else if (tick_q) begin
        deb_cnt_q <= deb_cnt_q + DEB_W'(1);
      end
    end
  end

  assign acq_apply = acq_cfg.delay_en;
  assign frm_apply = frm_cfg.delay_en && scheme == TDD_SCHEME_STANDARD;

  tdd_delay #(.W(DLY_W)) u_acq (
    .clk         (clk),
    .rst_n       (rst_n),
    .tick        (tick_q),
    .hw_edge     (hw_edge_q && acq_cfg.mode == TDD_MODE_ON && !acq_cfg.sw_source),
    .apply_delay (acq_apply),
    .delay_us    ((acq_cfg.delay_us > DLY_W'(DLY_MAX_US)) ? DLY_W'(DLY_MAX_US) : acq_cfg.delay_us),
    .fire_q      (acq_fire),
    .busy_q      (acq_busy)
  );

  tdd_delay #(.W(DLY_W)) u_frm (
    .clk         (clk),
    .rst_n       (rst_n),
    .tick        (tick_q),
    .hw_edge     (hw_edge_q && frm_cfg.mode == TDD_MODE_ON && !frm_cfg.sw_source
                  && scheme == TDD_SCHEME_STANDARD),
    .apply_delay (frm_apply),
    .delay_us    ((frm_cfg.delay_us > DLY_W'(DLY_MAX_US)) ? DLY_W'(DLY_MAX_US) : frm_cfg.delay_us),
    .fire_q      (frm_fire),
    .busy_q      (frm_busy)
  );

  // undelayed internal and software triggers
  assign acq_sw = (acq_cfg.mode == TDD_MODE_OFF) ? internal_acq
                  : (acq_cfg.sw_source && acq_cfg.sw_fire);
  assign frm_sw = (frm_cfg.mode == TDD_MODE_OFF) ? internal_frm
                  : (frm_cfg.sw_source && frm_cfg.sw_fire);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acq_out_q <= '0;
      frm_out_q <= '0;
    end else begin
      acq_out_q <= '{fire: acq_fire | acq_sw, busy: acq_busy};
      frm_out_q <= '{fire: frm_fire | frm_sw, busy: frm_busy};
    end
  end
endmodule

// [src/tdd_pkg.sv]
// Purpose: shared constants and types for trigger debounce and delay
// Assumes: 200 MHz system clock
// Notes:   times in microseconds; cycle counts derived here
package tdd_pkg;

  localparam int unsigned CLK_MHZ          = 200;
  localparam int unsigned TICK_NS          = 1000;
  localparam int unsigned CLK_PERIOD_NS    = 5;
  localparam int unsigned TICK_CYCLES      = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned DEB_MAX_US       = 1000000;
  localparam int unsigned DLY_MAX_US       = 10000000;
  localparam int unsigned DEB_W            = 20;
  localparam int unsigned DLY_W            = 24;
  localparam logic        LINE_RST         = 1'b0;
  localparam logic [1:0]  LINE_SEL_FIRST   = 2'h1;

  typedef enum logic [1:0] {
    TDD_SEL_ACQ_START,
    TDD_SEL_FRAME_START
  } tdd_sel_e;

  typedef enum logic {
    TDD_SCHEME_STANDARD,
    TDD_SCHEME_LEGACY
  } tdd_scheme_e;

  typedef enum logic {
    TDD_MODE_OFF,
    TDD_MODE_ON
  } tdd_mode_e;

  // per-trigger configuration
  typedef struct packed {
    tdd_mode_e          mode;
    logic               sw_source;
    logic               sw_fire;
    logic               delay_en;
    logic [DLY_W-1:0]   delay_us;
  } tdd_trig_cfg_s;

  // per-trigger output
  typedef struct packed {
    logic               fire;
    logic               busy;
  } tdd_trig_out_s;

endpackage

// [src/tdd_delay.sv]
// Purpose: one trigger delay channel counted in microsecond ticks
// Assumes: tick is a one-cycle pulse every microsecond
// Notes:   new triggers while a delay runs are ignored
`timescale 1ns/1ps
module tdd_delay
  import tdd_pkg::*;
#(
  parameter int unsigned W = tdd_pkg::DLY_W
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // timebase
  input  wire logic         tick,
  // trigger in
  input  wire logic         hw_edge,
  input  wire logic         apply_delay,
  input  wire logic [W-1:0] delay_us,
  // trigger out
  output logic              fire_q,
  output logic              busy_q
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q  <= '0;
      fire_q <= 1'b0;
    end else begin
      fire_q <= 1'b0;
      if (!busy_q) begin
        if (hw_edge) begin
          if (!apply_delay || delay_us == '0) begin
            fire_q <= 1'b1;
          end else begin
            busy_q <= 1'b1;
            cnt_q  <= delay_us;
          end
        end
      end else if (tick) begin
        if (cnt_q == W'(1)) begin
          busy_q <= 1'b0;
          fire_q <= 1'b1;
        end
        cnt_q <= cnt_q - W'(1);
      end
    end
  end
endmodule

// [testbench/tdd_top_asserts.sv]
// Purpose: timing checks on the trigger debounce and delay ports
// Assumes: bench uses 3 us debounce and 5 us acquisition delay
// Notes:   bound to tdd_top
`timescale 1ns/1ps
module tdd_top_asserts
  import tdd_pkg::*;
(
  input wire logic                   clk, nrst, first_input_line, line_debounced_q, internal_acq,
  input wire tdd_pkg::tdd_scheme_e   scheme,
  input wire tdd_pkg::tdd_trig_cfg_s acq_cfg, frm_cfg,
  input wire tdd_pkg::tdd_trig_out_s acq_out_q, frm_out_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire hw_acq = acq_cfg.mode == TDD_MODE_ON && !acq_cfg.sw_source;
  logic [11:0] busy_len_q;
  // cycles the acquisition delay has been busy, saturating
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) busy_len_q <= 12'h000;
    else if (!acq_out_q.busy) busy_len_q <= 12'h000;
    else if (busy_len_q != 12'hfff) busy_len_q <= busy_len_q + 12'h001;
  end
  property p_pulse; acq_out_q.fire |=> !acq_out_q.fire; endproperty
  a_pulse: assert property (p_pulse) else $error("acq fire too long");
  property p_quiet; (first_input_line == line_debounced_q)[*8] |=> $stable(line_debounced_q);
  endproperty
  a_quiet: assert property (p_quiet) else $error("debounced level moved");
  property p_hold; $rose(line_debounced_q) |-> $past(first_input_line, 2) && $past(first_input_line, 8);
  endproperty
  a_hold: assert property (p_hold) else $error("rise without held input");
  property p_start; $rose(line_debounced_q) && hw_acq && acq_cfg.delay_en && !acq_out_q.busy
    |-> ##[1:3] acq_out_q.busy; endproperty
  a_start: assert property (p_start) else $error("delay not started");
  property p_delay; $fell(acq_out_q.busy) && acq_cfg.delay_us == 24'h5
    |-> acq_out_q.fire && busy_len_q >= 12'h30c && busy_len_q <= 12'h4b0; endproperty
  a_delay: assert property (p_delay) else $error("delay length wrong");
  property p_legacy; scheme == TDD_SCHEME_LEGACY && frm_cfg.mode == TDD_MODE_ON
    && !frm_cfg.sw_source |-> !frm_out_q.fire; endproperty
  a_legacy: assert property (p_legacy) else $error("legacy frame fired");
  property p_int; acq_cfg.mode == TDD_MODE_OFF && internal_acq |-> ##[1:2] acq_out_q.fire;
  endproperty
  a_int: assert property (p_int) else $error("internal acq delayed");
  property p_sw; frm_cfg.mode == TDD_MODE_ON && frm_cfg.sw_source && frm_cfg.sw_fire
    |-> ##[1:2] frm_out_q.fire; endproperty
  a_sw: assert property (p_sw) else $error("software frame delayed");
endmodule
bind tdd_top tdd_top_asserts u_chk (.clk, .nrst, .first_input_line, .line_debounced_q,
  .internal_acq, .scheme, .acq_cfg, .frm_cfg, .acq_out_q, .frm_out_q);

// [testbench/tdd_trig_src.sv]
// Purpose: external trigger source on the first input line
// Assumes: line idles low
// Notes:   pulse width in clock cycles
`timescale 1ns/1ps
module tdd_trig_src (
  input wire logic clk,
  output logic     line
);
  initial line = 1'b0;
  task automatic pulse(input int n);
    @(posedge clk);
    #1 line = 1'b1;
    repeat (n) @(posedge clk);
    #1 line = 1'b0;
  endtask
endmodule

// [testbench/trigger_input_debounce_delay_bench.sv]
// Purpose: self-checking bench for tdd_top
// Assumes: 200 MHz clock
// Notes:   latencies checked against windows from the set times
`timescale 1ns/1ps
module trigger_input_debounce_delay_bench;
  import tdd_pkg::*;
  logic clk = 0, nrst = 0, line, line_deb, int_acq = 0;
  logic [DEB_W-1:0] deb = 20'h3;
  logic [31:0] lfsr = 32'h9970;
  tdd_scheme_e scheme = TDD_SCHEME_STANDARD;
  tdd_trig_cfg_s acq_cfg = '{TDD_MODE_ON, 1'b0, 1'b0, 1'b1, 24'h5};
  tdd_trig_cfg_s frm_cfg = '{TDD_MODE_ON, 1'b0, 1'b0, 1'b0, 24'h0};
  tdd_trig_out_s acq_o, frm_o;
  int fail_count, samples_checked, t, t_line, t_deb, t_acq, t_frm, tk = TICK_CYCLES;
  tdd_trig_src src (.clk(clk), .line(line));
  tdd_top dut (.clk(clk), .nrst(nrst), .first_input_line(line), .line_sel(LINE_SEL_FIRST),
    .debounce_us(deb), .debounce_wr_val(deb), .scheme(scheme), .acq_cfg(acq_cfg),
    .frm_cfg(frm_cfg), .internal_acq(int_acq), .internal_frm(1'b0),
    .line_debounced_q(line_deb), .acq_out_q(acq_o), .frm_out_q(frm_o));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    t++;
    if (line === 1'b1 && t_line < 0) t_line = t;
    if (line_deb === 1'b1 && t_deb < 0) t_deb = t;
    if (acq_o.fire === 1'b1) t_acq = t;
    if (frm_o.fire === 1'b1) t_frm = t;
  end
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
    t_line = -1; t_deb = -1; t_acq = -1; t_frm = -1;
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000 fail_count++;
    complete_run;
  end
  initial begin
    step(3);
    nrst = 1;
    step(3);
    lfsr = lfsr_next(lfsr);
    src.pulse(lfsr % 400 + 50);
    repeat (1500) @(posedge clk);
    chk("glitch level", t_deb, -1);
    chk("glitch fire", t_acq, -1);
    $display("glitch test done");
    step(1);
    src.pulse(1000);
    repeat (2000) @(posedge clk);
    chk("debounce time", (t_deb - t_line) inside {[3*tk:4*tk+4]}, 1);
    chk("acq delay", (t_acq - t_deb) inside {[4*tk:6*tk+4]}, 1);
    chk("frame no delay", (t_frm - t_deb) inside {[1:3]}, 1);
    $display("valid edge test done");
    step(1);
    acq_cfg.mode = TDD_MODE_OFF;
    frm_cfg.sw_source = 1'b1;
    int_acq = 1'b1;
    frm_cfg.sw_fire = 1'b1;
    @(posedge clk);
    #1 int_acq = 1'b0;
    frm_cfg.sw_fire = 1'b0;
    repeat (4) @(posedge clk);
    chk("internal acq", t_acq >= 0, 1);
    chk("software frame", t_frm >= 0, 1);
    $display("bypass test done");
    step(1);
    scheme = TDD_SCHEME_LEGACY;
    acq_cfg.mode = TDD_MODE_ON;
    frm_cfg.sw_source = 1'b0;
    src.pulse(1000);
    repeat (2000) @(posedge clk);
    chk("legacy frame", t_frm, -1);
    chk("legacy acq", t_acq >= 0, 1);
    $display("legacy test done");
    complete_run;
  end
endmodule
